// ===== design/pst_bus_clk_div.sv
// Divides pclk by two to make the card bus clock and its phase
`timescale 1ns/100ps
module pst_bus_clk_div (
   // Clock, enable and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Bus clock level, high during the first half of a bus cycle
   output logic      bus_clk
);

   logic bus_clk_q;   // Divided clock

   // Toggle on every enabled pclk edge: one pclk is half a bus cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_clk_q <= 1'b0;
      end else if (ce) begin
         bus_clk_q <= ~bus_clk_q;
      end
   end

   assign bus_clk = bus_clk_q;

endmodule

// ===== design/pst_defines.svh
// Offsets, field positions, reset values and counts of the strobe timing block
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH

// Register byte offsets on APB
`define PST_TIMING_OFS    12'h000
`define PST_STATUS_OFS    12'h004

// Timing register reset value and stored width
`define PST_TIMING_RST    8'h00

// Field positions in the timing register (low bit of each 2-bit field)
`define PST_A5_ASSERT_POS 6
`define PST_A6_ASSERT_POS 4
`define PST_A5_HOLD_POS   2
`define PST_A6_HOLD_POS   0

// Status register bit positions
`define PST_ST_BUSY_POS   0
`define PST_ST_STROBE_POS 1
`define PST_ST_AREA6_POS  2
`define PST_ST_WRITE_POS  3

// Strobe low time in half bus cycles (pclk cycles)
`define PST_STROBE_HALVES 4'h8

`endif

// ===== design/pst_half_cnt.sv
// Half bus cycle down counter used to time each phase of an access
`timescale 1ns/100ps
module pst_half_cnt (
   // Clock, enable and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Load control
   input  wire logic       load,
   input  wire logic [3:0] load_val,
   // Last cycle of the loaded span
   output logic            last
);

   logic [3:0] cnt_q;   // Remaining half cycles

   // Load wins over counting; hold at zero when idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= load_val;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end

   // A span of N lasts exactly N cycles after its load
   assign last = (cnt_q == 4'h1);

endmodule

// ===== design/pst_pkg.sv
// Types shared by the strobe timing block
package pst_pkg;

   // Phases of one card access
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_DONE
   } pst_state_t;

   // Two-bit delay code: 0.5, 1.5, 2.5 or 3.5 bus cycles
   typedef logic [1:0] pst_code_t;

endpackage

// ===== design/pst_timing_ctrl.sv
// PCMCIA strobe timing register and access sequencer for areas 5 and 6
// Notes on behaviour
// - Bits 15:8 of timing register read zero
// - Bits 7:6 set area 5 assert delay
// - Bits 5:4 set area 6 assert delay
// - Bits 3:2 set area 5 negate hold
// - Bits 1:0 set area 6 negate hold
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "pst_defines.svh"
module pst_timing_ctrl
   import pst_pkg::*;
(
   // Clock, enable and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // User request port
   input  wire logic        req,
   input  wire logic        req_area6,
   input  wire logic        req_write,
   input  wire logic [25:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             req_ack,
   output logic      [15:0] req_rdata,
   output logic             busy,
   // Card pins
   output logic             card_bus_clk,
   output logic      [25:0] card_addr,
   output logic             card_oe_n,
   output logic             card_we_n,
   output logic      [15:0] card_data_out,
   output logic             card_data_oe_n,
   input  wire logic [15:0] card_data_in
);

   // APB state
   logic [7:0]  timing_q;    // Stored low byte of timing register
   logic [31:0] prdata_q;    // Read data, loaded in setup phase
   logic [31:0] prdata_d;
   logic        pready_q;    // High for the one access cycle
   logic        pslverr_q;   // Error for unmapped offsets
   logic        pslverr_d;

   // Sequencer state
   pst_state_t  st_q;        // Access phase
   pst_state_t  st_d;
   pst_code_t   hold_code_q; // Hold delay snapshot for this access
   logic        area6_q;     // Area of current access
   logic        write_q;     // Direction of current access
   logic [25:0] addr_q;      // Card address
   logic [25:0] addr_d;
   logic [15:0] wdata_q;     // Card write data
   logic        oe_n_q;      // Output enable strobe
   logic        oe_n_d;
   logic        we_n_q;      // Write enable strobe
   logic        we_n_d;
   logic        data_oe_n_q; // Low while driving card data
   logic        data_oe_n_d;
   logic [15:0] rdata_q;     // Read data returned to user
   logic        ack_q;       // One-cycle done pulse
   logic        busy_q;      // Access in progress

   // Counter and divider wires
   logic        bus_clk;     // Divided bus clock level
   logic        span_last;   // Last cycle of current phase
   logic        cnt_load;    // Load counter at phase change
   logic [3:0]  cnt_val;     // Half cycles for next phase

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------

   // Setup and completing access phase
   wire setup_ph   = psel & ~penable;
   wire acc_done   = psel & penable & pready_q;

   // Address hits
   wire hit_timing = (paddr == `PST_TIMING_OFS);
   wire hit_status = (paddr == `PST_STATUS_OFS);
   wire hit_any    = hit_timing | hit_status;

   // Write strobe for the timing register, only at the completing edge
   wire wr_timing  = acc_done & pwrite & hit_timing;

   // Upper byte is reserved and always reads zero
   wire [31:0] rd_timing = {24'h000000, timing_q};

   // Status shows the sequencer's live state
   wire strobe_on = ~oe_n_q | ~we_n_q;
   wire [31:0] rd_status = {28'h0000000,
                            write_q,
                            area6_q,
                            strobe_on,
                            busy_q};

   // Read mux: unmapped offsets read zero
   wire [31:0] rd_mux = hit_timing ? rd_timing :
                        hit_status ? rd_status : 32'h00000000;

   // Read data latched in setup so it stands through the access
   assign prdata_d  = (setup_ph & ~pwrite) ? rd_mux : prdata_q;

   // Unmapped offsets answer with an error
   assign pslverr_d = setup_ph & ~hit_any;

   // ---------------------------------------------------------------
   // APB registers
   // ---------------------------------------------------------------

   // Timing register: the reserved byte is dropped on write, so a
   // careless write of ones there cannot reach the fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_q <= `PST_TIMING_RST;
      end else if (clk_en && wr_timing) begin
         timing_q <= pwdata[7:0];
      end
   end

   // Answer registers: one wait-free access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         prdata_q  <= prdata_d;
         pready_q  <= setup_ph;
         pslverr_q <= pslverr_d;
      end
   end

   // ---------------------------------------------------------------
   // Delay field selection
   // ---------------------------------------------------------------

   // Area 5 and area 6 assert delay fields
   wire pst_code_t a5_asrt = timing_q[`PST_A5_ASSERT_POS +: 2];
   wire pst_code_t a6_asrt = timing_q[`PST_A6_ASSERT_POS +: 2];

   // Area 5 and area 6 negate hold fields
   wire pst_code_t a5_hold = timing_q[`PST_A5_HOLD_POS +: 2];
   wire pst_code_t a6_hold = timing_q[`PST_A6_HOLD_POS +: 2];

   // Codes for the requesting area
   wire pst_code_t asrt_sel = req_area6 ? a6_asrt : a5_asrt;
   wire pst_code_t hold_sel = req_area6 ? a6_hold : a5_hold;

   // Code c means c + 0.5 bus cycles, i.e. 2c + 1 half cycles
   wire [3:0] asrt_halves = {1'b0, asrt_sel, 1'b1};
   wire [3:0] hold_halves = {1'b0, hold_code_q, 1'b1};

   // ---------------------------------------------------------------
   // Half-cycle timing base
   // ---------------------------------------------------------------

   // Bus clock is pclk / 2, so every pclk edge is a half bus cycle
   pst_bus_clk_div u_div (
      .clk     (pclk),
      .rst_n   (presetn),
      .ce      (clk_en),
      .bus_clk (bus_clk)
   );

   // Phase timer in half bus cycles
   pst_half_cnt u_cnt (
      .clk      (pclk),
      .rst_n    (presetn),
      .ce       (clk_en),
      .load     (cnt_load),
      .load_val (cnt_val),
      .last     (span_last)
   );

   // Start only when the bus clock is about to rise, so the address
   // leaves on a rising bus clock edge
   wire start = (st_q == ST_IDLE) & req & ~bus_clk;

   // Phase ends
   wire setup_end  = (st_q == ST_SETUP)  & span_last;
   wire strobe_end = (st_q == ST_STROBE) & span_last;
   wire hold_end   = (st_q == ST_HOLD)   & span_last;

   // Counter loads for the next phase
   assign cnt_load = start | setup_end | strobe_end;
   assign cnt_val  = start      ? asrt_halves :
                     setup_end  ? `PST_STROBE_HALVES :
                     hold_halves;

   // ---------------------------------------------------------------
   // Sequencer next state
   // ---------------------------------------------------------------

   // Address, strobe, hold, then a one-cycle acknowledge
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: begin
            if (start) begin
               st_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (span_last) begin
               st_d = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (span_last) begin
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (span_last) begin
               st_d = ST_DONE;
            end
         end
         ST_DONE: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Address is taken at start and held until the next access starts
   assign addr_d = start ? req_addr : addr_q;

   // Direction for the coming cycle
   wire write_d_sel = start ? req_write : write_q;

   // Strobe low only in the strobe phase; leaves it on the pclk edge
   // that ends the phase, i.e. on a half bus cycle boundary
   assign oe_n_d = ~((st_d == ST_STROBE) & ~write_d_sel);
   assign we_n_d = ~((st_d == ST_STROBE) &  write_d_sel);

   // Data driven from address out to end of hold on writes
   wire in_access = (st_d == ST_SETUP) | (st_d == ST_STROBE) |
                    (st_d == ST_HOLD);
   assign data_oe_n_d = ~(in_access & write_d_sel);

   // ---------------------------------------------------------------
   // Sequencer registers
   // ---------------------------------------------------------------

   // Phase register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // Access snapshot: a register write mid-access cannot stretch or
   // cut the hold time of the access already under way
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_code_q <= 2'h0;
         area6_q     <= 1'b0;
         write_q     <= 1'b0;
         wdata_q     <= 16'h0000;
      end else if (clk_en && start) begin
         hold_code_q <= hold_sel;
         area6_q     <= req_area6;
         write_q     <= req_write;
         wdata_q     <= req_wdata;
      end
   end

   // Pin registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q      <= 26'h0000000;
         oe_n_q      <= 1'b1;
         we_n_q      <= 1'b1;
         data_oe_n_q <= 1'b1;
      end else if (clk_en) begin
         addr_q      <= addr_d;
         oe_n_q      <= oe_n_d;
         we_n_q      <= we_n_d;
         data_oe_n_q <= data_oe_n_d;
      end
   end

   // Read data sampled in the last strobe cycle, before OE rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 16'h0000;
      end else if (clk_en && strobe_end && !write_q) begin
         rdata_q <= card_data_in;
      end
   end

   // Handshake flags to the user side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q  <= 1'b0;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         ack_q  <= hold_end;
         busy_q <= (st_d != ST_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // APB answer
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // User side
   assign req_ack   = ack_q;
   assign req_rdata = rdata_q;
   assign busy      = busy_q;

   // Card side
   assign card_bus_clk   = bus_clk;
   assign card_addr      = addr_q;
   assign card_oe_n      = oe_n_q;
   assign card_we_n      = we_n_q;
   assign card_data_out  = wdata_q;
   assign card_data_oe_n = data_oe_n_q;

endmodule

// ===== dv/pst_card_model.sv
// Behavioural card on areas 5 and 6: answers reads, records writes
`timescale 1ns/100ps
module pst_card_model (
   // Clock
   input  wire logic        pclk,
   // Pins from the controller
   input  wire logic [25:0] card_addr,
   input  wire logic        card_oe_n,
   input  wire logic        card_we_n,
   input  wire logic [15:0] card_data_out,
   // Read data back
   output logic      [15:0] card_data_in
);
   logic [15:0] last_q = 16'h0000; // Last value on the data lines
   logic [15:0] wr_q;              // Last word written by the controller
   // Released lines flip every cycle, so a late sample cannot pass by luck
   assign card_data_in = !card_oe_n ? (card_addr[15:0] ^ 16'h5A3C) : ~last_q;
   // Track the lines and catch write data while the write strobe is low
   always_ff @(posedge pclk) begin
      last_q <= card_data_in;
      if (!card_we_n)
         wr_q <= card_data_out;
   end
endmodule

// ===== dv/pst_timing_ctrl_bench.sv
// Self-checking bench of the strobe timing block
`timescale 1ns/100ps
module pst_timing_ctrl_bench;
   import pst_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, req = 1'b0, req_area6 = 1'b0, req_write = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [25:0] req_addr = 26'h0, card_addr;
   logic [15:0] req_wdata = 16'h0, req_rdata, card_data_out, card_data_in;
   logic        pready, pslverr, req_ack, busy, card_bus_clk, card_oe_n, card_we_n;
   logic        card_data_oe_n;
   int          err_count = 0, n_tests = 0;
   // 250 MHz clock
   always #2 pclk = ~pclk;
   // Block under test
   pst_timing_ctrl dut (
      .pclk           (pclk),
      .presetn        (presetn),
      .clk_en         (clk_en),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .req            (req),
      .req_area6      (req_area6),
      .req_write      (req_write),
      .req_addr       (req_addr),
      .req_wdata      (req_wdata),
      .req_ack        (req_ack),
      .req_rdata      (req_rdata),
      .busy           (busy),
      .card_bus_clk   (card_bus_clk),
      .card_addr      (card_addr),
      .card_oe_n      (card_oe_n),
      .card_we_n      (card_we_n),
      .card_data_out  (card_data_out),
      .card_data_oe_n (card_data_oe_n),
      .card_data_in   (card_data_in)
   );
   // Card at the far side
   pst_card_model u_card (
      .pclk          (pclk),
      .card_addr     (card_addr),
      .card_oe_n     (card_oe_n),
      .card_we_n     (card_we_n),
      .card_data_out (card_data_out),
      .card_data_in  (card_data_in)
   );
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A wait ran out: count it and close
   task automatic stuck;
      err_count++;
      report_and_stop;
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
         stuck;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset values, timing write and read back, status and an unmapped offset
   task automatic s_regs;
      logic [31:0] r;
      logic        e;
      logic        b;
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b1, 12'h000, 32'h0000_00E7, r, e);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk(r, 32'h0000_00E7);
      chk({31'h0, e}, 32'h0);
      apb(1'b0, 12'h004, 32'h0, r, e);
      chk(r, 32'h0);
      apb(1'b0, 12'h008, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      // Clock enable low: the bus clock divider must stand still
      clk_en <= 1'b0;
      @(posedge pclk);
      b = card_bus_clk;
      repeat (3) @(posedge pclk);
      chk({31'h0, card_bus_clk}, {31'h0, b});
      clk_en <= 1'b1;
   endtask
   // One card access with the given codes; the other area gets inverted codes
   task automatic access(input logic a6, input logic w, input pst_code_t ac, input pst_code_t hc);
      int          j;
      int          t_fall;
      int          t_ack;
      logic        doe;
      logic [31:0] r;
      logic        e;
      apb(1'b1, 12'h000, {24'h0, a6 ? {~ac, ac, ~hc, hc} : {ac, ~ac, hc, ~hc}}, r, e);
      @(posedge pclk);
      req <= 1'b1;
      req_area6 <= a6;
      req_write <= w;
      req_addr <= {20'hABCDE, ac, hc, 2'h1};
      req_wdata <= {12'h3C5, ac, hc};
      j = 0;
      while (busy !== 1'b1) begin
         @(posedge pclk);
         j++;
         if (j > 8)
            stuck;
      end
      // Access starts only on a low bus clock, so it is high one cycle later
      chk({31'h0, card_bus_clk}, 32'h1);
      j = 0;
      doe = 1'b1;
      t_fall = -1;
      t_ack = -1;
      while (t_ack < 0) begin
         @(posedge pclk);
         j++;
         if (t_fall < 0 && (card_oe_n === 1'b0 || card_we_n === 1'b0)) begin
            t_fall = j;
            doe = card_data_oe_n;
         end
         if (req_ack === 1'b1) begin
            t_ack = j;
            req <= 1'b0;
         end
         if (j > 40)
            stuck;
      end
      chk(32'(t_fall), 32'(2 * ac + 1));
      chk(32'(t_ack), 32'(2 * ac + 2 * hc + 10));
      // Data lines driven under the strobe on writes only
      chk({31'h0, doe}, {31'h0, ~w});
      if (w)
         chk({16'h0, u_card.wr_q}, {16'h0, req_wdata});
      else
         chk({16'h0, req_rdata}, {16'h0, req_addr[15:0] ^ 16'h5A3C});
   endtask
   // Every code of every field, reads and writes on both areas
   task automatic s_sweep;
      for (int c = 0; c < 4; c++) begin
         access(1'b0, c[0], pst_code_t'(c), pst_code_t'(3 - c));
         access(1'b1, !c[0], pst_code_t'(c), pst_code_t'(c));
      end
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs;
      s_sweep;
      report_and_stop;
   end
endmodule

// ===== dv/pst_timing_ctrl_sva.sv
// Port checker of the strobe timing block
`timescale 1ns/100ps
`include "pst_defines.svh"
module pst_timing_sva
   import pst_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // User side and strobes
   input wire logic        req_area6,
   input wire logic        req_ack,
   input wire logic        busy,
   input wire logic        card_oe_n,
   input wire logic        card_we_n
);
   logic [7:0] tim_q; // Shadow of the timing fields
   logic [4:0] cnt_q; // Cycles since the access began
   pst_code_t  ac_q;  // Assert code of this access
   pst_code_t  hc_q;  // Hold code of this access
   wire        strb   = !(card_oe_n && card_we_n);
   wire        tim_wr = psel && penable && pready && pwrite && paddr == `PST_TIMING_OFS;
   // Shadow register, access timer and code snapshot at access start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tim_q <= 8'h00;
         cnt_q <= 5'h00;
         ac_q  <= 2'h0;
         hc_q  <= 2'h0;
      end else begin
         if (tim_wr)
            tim_q <= pwdata[7:0];
         cnt_q <= busy ? cnt_q + 5'h01 : 5'h00;
         // Codes are read from the live register in the first busy cycle
         if (busy && cnt_q == 5'h00) begin
            ac_q <= req_area6 ? tim_q[5:4] : tim_q[7:6];
            hc_q <= req_area6 ? tim_q[1:0] : tim_q[3:2];
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no access cycle after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_upper_zero: assert property (pready && !pwrite && paddr == `PST_TIMING_OFS
      |-> prdata == {24'h0, tim_q}) else $error("timing read back wrong");
   a_assert_delay: assert property ($rose(strb)
      |-> cnt_q == {2'h0, ac_q, 1'b1}) else $error("assert delay wrong");
   a_ack_delay: assert property ($rose(req_ack)
      |-> cnt_q == {2'h0, ac_q, 1'b1} + 5'h08 + {2'h0, hc_q, 1'b1})
      else $error("hold delay wrong");
   a_strobe_width: assert property ($rose(strb) |=> strb [*7] ##1 !strb)
      else $error("strobe not eight cycles");
   a_strobes_excl: assert property (card_oe_n || card_we_n)
      else $error("both strobes low");
   a_ack_pulse: assert property (req_ack |-> busy ##1 (!busy && !req_ack))
      else $error("ack not a single pulse in the last busy cycle");
   c_tim_write: cover property (tim_wr);
   c_slow_assert: cover property ($rose(strb) && ac_q == 2'h3);
   c_slow_hold: cover property ($rose(req_ack) && hc_q == 2'h3);
endmodule
bind pst_timing_ctrl pst_timing_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .req_area6(req_area6), .req_ack(req_ack), .busy(busy),
   .card_oe_n(card_oe_n), .card_we_n(card_we_n));
